// >>> rtl/bcr_avg.sv
`timescale 1ns/1ns
// repeats the kick-back conversion 1, 2, 4 or 8 times and averages
module bcr_avg
	import bcr_pkg::*;
(
	input wire logic ref_clk_i, // device clock
	input wire logic nrst_i, // async reset, active low
	input wire logic start_i, // one-cycle start pulse
	input wire logic [1:0] avg_sel_i, // log2 of conversion count
	input wire logic conv_done_i, // conversion finished pulse
	input wire logic [BCR_CODE_W-1:0] conv_data_i, // conversion result
	output logic conv_start_o, // starts one conversion
	output logic done_o, // averaged result valid pulse
	output logic [BCR_CODE_W-1:0] result_o // averaged code
);

	bcr_avg_regs_t r;
	bcr_avg_regs_t n;
	logic [BCR_ACC_W-1:0] acc_sum;

	always_comb
	begin
		n = r;
		n.conv_start = 1'b0;
		n.done = 1'b0;
		acc_sum = r.acc + {{(BCR_ACC_W-BCR_CODE_W){1'b0}}, conv_data_i};
		if (!r.busy && start_i)
		begin
			n.busy = 1'b1;
			n.sel = avg_sel_i;
			n.left = 4'(4'h1 << avg_sel_i);
			n.acc = '0;
			n.conv_start = 1'b1;
		end
		else if (r.busy && conv_done_i)
		begin
			n.acc = acc_sum;
			n.left = r.left - 4'h1;
			if (r.left == 4'h1)
			begin
				// power-of-two count, so the mean is a plain shift
				n.busy = 1'b0;
				n.done = 1'b1;
				n.result = BCR_CODE_W'(acc_sum >> r.sel);
			end
			else
			begin
				n.conv_start = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			r <= '0;
		else
			r <= n;
	end

	assign conv_start_o = r.conv_start;
	assign done_o = r.done;
	assign result_o = r.result;

endmodule : bcr_avg

// >>> rtl/bcr_pkg.sv
package bcr_pkg;

	////////////////////////////////////////////////////////////////////
	// register map (byte addresses on the register port)
	localparam logic [7:0] BCR_OFS_BIAS_LO = 8'h03;
	localparam logic [7:0] BCR_OFS_BIAS_HI = 8'h04;
	localparam logic [7:0] BCR_OFS_IRQ_EN = 8'h05;

	// reset values
	localparam logic [7:0] BCR_RST_BIAS_LO = 8'h7D;
	localparam logic [7:0] BCR_RST_BIAS_HI = 8'h04;
	localparam logic [7:0] BCR_RST_IRQ_EN = 8'h7F;

	// fields of the upper bias / control register
	localparam int BCR_BIT_MEASURE_START = 7;
	localparam int BCR_BIT_COMMIT_NVM = 6;
	localparam int BCR_BIT_PIN_FLOAT = 5;
	localparam int BCR_BIT_AVG_HI = 4;
	localparam int BCR_BIT_AVG_LO = 3;
	localparam int BCR_BIT_CODE8 = 0;

	// fields of the first interrupt-enable register
	localparam int BCR_BIT_TEMP_CHANGE_EN = 7;
	localparam int BCR_BIT_WR_EN_HI = 6;
	localparam int BCR_BIT_WR_EN_LO = 2;
	localparam int BCR_BIT_MEASURE_DONE_EN = 1;
	localparam int BCR_BIT_PROGRAM_DONE_EN = 0;

	// bias code: output voltage = code * step
	localparam int BCR_CODE_W = 9;
	localparam int BCR_BIAS_STEP_MV = -10;
	localparam int BCR_ACC_W = 12;
	localparam int BCR_WR_EN_W = 5;

	////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		BCR_ST_IDLE = 3'h1,
		BCR_ST_MEASURE = 3'h2,
		BCR_ST_COMMIT = 3'h4
	} bcr_state_t;

	typedef struct packed {
		bcr_state_t st;
		logic [7:0] bias_lo;
		logic [7:0] bias_hi;
		logic [BCR_WR_EN_W-1:0] irq_en_w;
		logic measure_done_flag;
		logic program_done_flag;
		logic meas_go;
		logic nvm_wr;
		logic standby;
		logic irq_oe_n;
		logic [7:0] rdata;
	} bcr_regs_t;

	typedef struct packed {
		logic busy;
		logic conv_start;
		logic [3:0] left;
		logic [1:0] sel;
		logic [BCR_ACC_W-1:0] acc;
		logic done;
		logic [BCR_CODE_W-1:0] result;
	} bcr_avg_regs_t;

endpackage : bcr_pkg

// >>> rtl/bcr_top.sv
`timescale 1ns/1ns
//
// Function
// - low bias byte 0x03, bit 8 at 0x04[0]
// - bias output is code times minus 10mV
// - low bias byte resets to 0x7D
// - upper bias register resets to 0x04
// - writing 1 starts measurement; 0 does nothing
// - measurement end clears start, stores result
// - averaging field selects 1,2,4,8 conversions
// - sequencer repeats conversions, returns average
// - commit bit stores code in nonvolatile memory
// - commit end clears bit, enters standby
// - float bit releases bias pin from amplifier
// - enabled source pulls interrupt low
// - interrupt enable register resets to 0x7F
// - shutdown bit 6, warning bit 5 writable
// - thermistor hot enable bit 4 writable
// - cold bit 3, undervoltage bit 2 writable
// - temperature-change enable reads 0, read-only
// - measure-done enable reads 1, read-only
// - program-done enable reads 1, read-only
// - measurement end sets measure-done flag
// - commit end sets program-done flag
module bcr_top
	import bcr_pkg::*;
(
	input wire logic ref_clk_i, // device clock, 100 MHz
	input wire logic nrst_i, // async reset, active low
	input wire logic reg_wr_i, // register write strobe
	input wire logic reg_rd_i, // register read strobe
	input wire logic [7:0] reg_addr_i, // register address
	input wire logic [7:0] reg_wdata_i, // register write data
	output logic [7:0] reg_rdata_o, // read data, one cycle later
	input wire logic [4:0] ext_irq_i, // sources of enable bits 6..2
	input wire logic [1:0] flag_clr_i, // [1] measure, [0] program
	output logic measure_done_flag_o, // measurement complete flag
	output logic program_done_flag_o, // commit complete flag
	output logic irq_out_n_o, // interrupt pin level (low)
	output logic irq_oe_n_o, // low while pin is pulled low
	output logic [BCR_CODE_W-1:0] bias_code_o, // backplane bias code
	output logic bias_pin_float_o, // high: amplifier off the pin
	output logic adc_start_o, // start one kick-back conversion
	input wire logic adc_done_i, // conversion finished pulse
	input wire logic [BCR_CODE_W-1:0] adc_data_i, // conversion code
	output logic nvm_write_o, // commit pulse to nonvolatile store
	output logic [BCR_CODE_W-1:0] nvm_data_o, // code to commit
	input wire logic nvm_done_i, // nonvolatile write finished
	output logic standby_req_o // enter standby pulse
);

	////////////////////////////////////////////////////////////////////
	bcr_regs_t r;
	bcr_regs_t n;
	logic avg_done;
	logic [BCR_CODE_W-1:0] avg_result;
	logic [7:0] irq_en_full;
	logic irq_any;
	logic [BCR_WR_EN_W-1:0] wdata_en;

	// only bits 6..2 of the enable register hold state
	assign wdata_en = reg_wdata_i[BCR_BIT_WR_EN_HI:BCR_BIT_WR_EN_LO];

	bcr_avg u_avg (
		.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i),
		.start_i(r.meas_go),
		.avg_sel_i(r.bias_hi[BCR_BIT_AVG_HI:BCR_BIT_AVG_LO]),
		.conv_done_i(adc_done_i),
		.conv_data_i(adc_data_i),
		.conv_start_o(adc_start_o),
		.done_o(avg_done),
		.result_o(avg_result)
	);

	// fixed bits are rebuilt on every read, so writes cannot touch them
	always_comb
	begin
		irq_en_full = 8'h00;
		irq_en_full[BCR_BIT_TEMP_CHANGE_EN] = 1'b0;
		irq_en_full[BCR_BIT_WR_EN_HI:BCR_BIT_WR_EN_LO] = r.irq_en_w;
		irq_en_full[BCR_BIT_MEASURE_DONE_EN] = 1'b1;
		irq_en_full[BCR_BIT_PROGRAM_DONE_EN] = 1'b1;
	end

	////////////////////////////////////////////////////////////////////
	always_comb
	begin
		n = r;
		n.meas_go = 1'b0;
		n.nvm_wr = 1'b0;
		n.standby = 1'b0;

		if (reg_wr_i)
		begin
			case (reg_addr_i)
				BCR_OFS_BIAS_LO: n.bias_lo = reg_wdata_i;
				BCR_OFS_BIAS_HI: n.bias_hi = reg_wdata_i;
				BCR_OFS_IRQ_EN:
					n.irq_en_w = wdata_en;
				default: n.bias_lo = n.bias_lo;
			endcase
		end

		// clears first so a completion in the same cycle still sets
		if (flag_clr_i[1])
			n.measure_done_flag = 1'b0;
		if (flag_clr_i[0])
			n.program_done_flag = 1'b0;

		case (r.st)
			BCR_ST_IDLE:
			begin
				// a zero in the start bit leaves the sequencer idle unless the commit bit is set
				if (r.bias_hi[BCR_BIT_MEASURE_START])
				begin
					n.st = BCR_ST_MEASURE;
					n.meas_go = 1'b1;
				end
				else if (r.bias_hi[BCR_BIT_COMMIT_NVM])
				begin
					n.st = BCR_ST_COMMIT;
					n.nvm_wr = 1'b1;
				end
			end
			BCR_ST_MEASURE:
			begin
				if (avg_done)
				begin
					n.bias_lo = avg_result[7:0];
					n.bias_hi[BCR_BIT_CODE8] = avg_result[8];
					n.bias_hi[BCR_BIT_MEASURE_START] = 1'b0;
					n.measure_done_flag = 1'b1;
					n.st = BCR_ST_IDLE;
				end
			end
			BCR_ST_COMMIT:
			begin
				if (nvm_done_i)
				begin
					n.bias_hi[BCR_BIT_COMMIT_NVM] = 1'b0;
					n.program_done_flag = 1'b1;
					n.standby = 1'b1;
					n.st = BCR_ST_IDLE;
				end
			end
			default: n.st = BCR_ST_IDLE;
		endcase

		// both done enables are fixed on; the temp-change source is absent
		irq_any = |(ext_irq_i & n.irq_en_w) | n.measure_done_flag
			| n.program_done_flag;
		n.irq_oe_n = ~irq_any;

		n.rdata = 8'h00;
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				BCR_OFS_BIAS_LO: n.rdata = r.bias_lo;
				BCR_OFS_BIAS_HI: n.rdata = r.bias_hi;
				BCR_OFS_IRQ_EN: n.rdata = irq_en_full;
				default: n.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			r <= '0;
			r.st <= BCR_ST_IDLE;
			r.bias_lo <= BCR_RST_BIAS_LO;
			r.bias_hi <= BCR_RST_BIAS_HI;
			r.irq_en_w <= BCR_RST_IRQ_EN[BCR_BIT_WR_EN_HI:BCR_BIT_WR_EN_LO];
			r.irq_oe_n <= 1'b1;
		end
		else
		begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////
	// bias voltage in mV is bias_code_o * BCR_BIAS_STEP_MV
	assign bias_code_o = {r.bias_hi[BCR_BIT_CODE8], r.bias_lo};
	assign bias_pin_float_o = r.bias_hi[BCR_BIT_PIN_FLOAT];
	assign reg_rdata_o = r.rdata;
	assign measure_done_flag_o = r.measure_done_flag;
	assign program_done_flag_o = r.program_done_flag;
	// the pin is only ever pulled low; released it floats high
	assign irq_out_n_o = r.irq_oe_n;
	assign irq_oe_n_o = r.irq_oe_n;
	assign nvm_write_o = r.nvm_wr;
	assign nvm_data_o = bias_code_o;
	assign standby_req_o = r.standby;

	////////////////////////////////////////////////////////////////////
	// conversions issued during the current measurement; the averaging
	// field is caught at start, as the host may rewrite it meanwhile
	logic [3:0] conv_cnt;
	logic [1:0] conv_sel;
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			conv_cnt <= 4'h0;
			conv_sel <= 2'h0;
		end
		else if (r.meas_go)
		begin
			conv_cnt <= 4'h0;
			conv_sel <= r.bias_hi[BCR_BIT_AVG_HI:BCR_BIT_AVG_LO];
		end
		else if (adc_start_o)
			conv_cnt <= conv_cnt + 4'h1;
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	measure_start_a: assert property (
		r.st == BCR_ST_IDLE && r.bias_hi[BCR_BIT_MEASURE_START]
		|=> r.st == BCR_ST_MEASURE ##1 adc_start_o)
		else $error("measurement did not start");

	idle_hold_a: assert property (
		r.st == BCR_ST_IDLE && !r.bias_hi[BCR_BIT_MEASURE_START]
		&& !r.bias_hi[BCR_BIT_COMMIT_NVM] |=> r.st == BCR_ST_IDLE)
		else $error("sequencer left idle without request");

	measure_end_a: assert property (
		r.st == BCR_ST_MEASURE && avg_done && !flag_clr_i[1]
		|=> !r.bias_hi[BCR_BIT_MEASURE_START] && measure_done_flag_o
		&& bias_code_o == $past(avg_result))
		else $error("measurement result not stored");

	conv_count_a: assert property (
		r.st == BCR_ST_MEASURE && avg_done
		|-> conv_cnt == 4'(4'h1 << conv_sel))
		else $error("wrong number of conversions");

	commit_go_a: assert property (
		r.st == BCR_ST_IDLE && !r.bias_hi[BCR_BIT_MEASURE_START]
		&& r.bias_hi[BCR_BIT_COMMIT_NVM]
		|=> nvm_write_o && nvm_data_o == $past(bias_code_o))
		else $error("commit not issued with current code");

	commit_end_a: assert property (
		r.st == BCR_ST_COMMIT && nvm_done_i && !flag_clr_i[0]
		|=> standby_req_o && program_done_flag_o
		&& !r.bias_hi[BCR_BIT_COMMIT_NVM] ##1 !standby_req_o)
		else $error("commit completion wrong");

	pin_float_a: assert property (
		reg_wr_i && reg_addr_i == BCR_OFS_BIAS_HI
		|=> bias_pin_float_o == $past(reg_wdata_i[BCR_BIT_PIN_FLOAT]))
		else $error("float bit not applied");

	flag_irq_a: assert property (
		measure_done_flag_o || program_done_flag_o
		|-> !irq_oe_n_o && !irq_out_n_o)
		else $error("done flag not driving interrupt");

	ro_enable_a: assert property (
		reg_rd_i && reg_addr_i == BCR_OFS_IRQ_EN
		|=> reg_rdata_o[7] == 1'b0 && reg_rdata_o[1:0] == 2'h3)
		else $error("read-only enables read wrong");

	code_read_a: assert property (
		reg_rd_i && reg_addr_i == BCR_OFS_BIAS_LO
		|=> reg_rdata_o == $past(r.bias_lo))
		else $error("low bias byte read wrong");

	code_write_a: assert property (
		reg_wr_i && reg_addr_i == BCR_OFS_BIAS_LO
		&& !(r.st == BCR_ST_MEASURE && avg_done)
		|=> r.bias_lo == $past(reg_wdata_i))
		else $error("low bias byte write lost");

	irq_write_a: assert property (
		reg_wr_i && reg_addr_i == BCR_OFS_IRQ_EN
		|=> r.irq_en_w == $past(wdata_en))
		else $error("writable enables not stored");

	irq_pin_a: assert property (
		1'b1 |=> irq_oe_n_o == !(|($past(ext_irq_i) & r.irq_en_w)
		|| measure_done_flag_o || program_done_flag_o))
		else $error("interrupt pin level wrong");

	standby_pulse_a: assert property (
		standby_req_o |-> program_done_flag_o && r.st == BCR_ST_IDLE
		&& !r.bias_hi[BCR_BIT_COMMIT_NVM])
		else $error("standby request without commit end");

	spare_bits_a: assert property (
		reg_wr_i && reg_addr_i == BCR_OFS_BIAS_HI
		|=> r.bias_hi[2:1] == $past(reg_wdata_i[2:1]))
		else $error("spare bits not stored");

	conv_in_measure_a: assert property (
		adc_start_o |-> r.st == BCR_ST_MEASURE)
		else $error("conversion started outside measurement");

endmodule : bcr_top

// >>> tb/bcr_far.sv
`timescale 1ns/1ns
// converter and nonvolatile store on the far side, prompt or slow
module bcr_far
	import bcr_pkg::*;
(
	input wire logic ref_clk_i, // device clock
	input wire logic nrst_i, // async reset, active low
	input wire logic [3:0] lat_i, // answer delay in cycles
	input wire logic [BCR_CODE_W-1:0] base_i, // base sample value
	input wire logic conv_start_i, // start one conversion
	output logic conv_done_o, // conversion finished pulse
	output logic [BCR_CODE_W-1:0] conv_data_o, // valid with done only
	input wire logic nvm_write_i, // commit request pulse
	output logic nvm_done_o // commit finished pulse
);
	logic [3:0] cwait, nwait;
	logic cbusy, nbusy;
	logic [2:0] idx;
	always_ff @(posedge ref_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			{cwait, nwait, cbusy, nbusy, idx} <= '0;
			{conv_done_o, nvm_done_o, conv_data_o} <= '0;
		end
		else
		begin
			conv_done_o <= 1'b0;
			nvm_done_o <= 1'b0;
			// stale data toggles so nothing can lean on a held value
			conv_data_o <= ~conv_data_o;
			if (conv_start_i)
			begin
				cbusy <= 1'b1;
				cwait <= lat_i;
			end
			else if (cbusy && cwait == 4'h0)
			begin
				cbusy <= 1'b0;
				conv_done_o <= 1'b1;
				conv_data_o <= base_i + {6'h00, idx};
				idx <= idx + 3'h1;
			end
			else if (cbusy)
				cwait <= cwait - 4'h1;
			if (nvm_write_i)
			begin
				nbusy <= 1'b1;
				nwait <= lat_i;
			end
			else if (nbusy && nwait == 4'h0)
			begin
				nbusy <= 1'b0;
				nvm_done_o <= 1'b1;
			end
			else if (nbusy)
				nwait <= nwait - 4'h1;
		end
	end
endmodule : bcr_far

// >>> tb/bcr_top_tb.sv
`timescale 1ns/1ns
module bcr_top_tb import bcr_pkg::*;;
	logic ref_clk_i, nrst_i, reg_wr_i, reg_rd_i, adc_done_i, nvm_done_i;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, m_lo, m_hi, m_en;
	logic [4:0] ext_irq_i;
	logic [1:0] flag_clr_i;
	logic measure_done_flag_o, program_done_flag_o, irq_out_n_o, irq_oe_n_o;
	logic bias_pin_float_o, adc_start_o, nvm_write_o, standby_req_o;
	logic [8:0] bias_code_o, adc_data_i, nvm_data_o, base;
	logic [3:0] lat;
	logic [31:0] seed;
	int mismatches, comparisons, cyc, n, i, j, k, e, c, starts;
	bcr_top bcr_top_inst (.ref_clk_i, .nrst_i, .reg_wr_i, .reg_rd_i,
		.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .ext_irq_i, .flag_clr_i,
		.measure_done_flag_o, .program_done_flag_o, .irq_out_n_o,
		.irq_oe_n_o, .bias_code_o, .bias_pin_float_o, .adc_start_o,
		.adc_done_i, .adc_data_i, .nvm_write_o, .nvm_data_o, .nvm_done_i,
		.standby_req_o);
	bcr_far bcr_far_inst (.ref_clk_i, .nrst_i, .lat_i(lat), .base_i(base),
		.conv_start_i(adc_start_o), .conv_done_o(adc_done_i),
		.conv_data_o(adc_data_i), .nvm_write_i(nvm_write_o),
		.nvm_done_o(nvm_done_i));
	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt
	task automatic conclude();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	// read data stands one cycle only, so it is sampled right away
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk({1'b0, reg_rdata_o}, {1'b0, x});
	endtask : rd
	task automatic regs();
		rd(BCR_OFS_BIAS_LO, m_lo);
		rd(BCR_OFS_BIAS_HI, m_hi);
		rd(BCR_OFS_IRQ_EN, m_en);
		chk(bias_code_o, {m_hi[0], m_lo});
		chk({8'h00, bias_pin_float_o}, {8'h00, m_hi[5]});
	endtask : regs
	// 0: measure flag, 1: commit pulse, 2: standby pulse
	function automatic logic evt(input int w);
		case (w)
			0: return measure_done_flag_o;
			1: return nvm_write_o;
			default: return standby_req_o;
		endcase
	endfunction : evt
	task automatic await(input int w);
		#1;
		k = 0;
		while (evt(w) !== 1'b1 && k < 300)
		begin
			@(posedge ref_clk_i);
			#1;
			k++;
		end
		if (k == 300)
		begin
			mismatches++;
			conclude();
		end
	endtask : await
	////////////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk_i = 1'b0;
		forever
			#5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i)
	begin
		cyc++;
		if (adc_start_o === 1'b1)
			starts++;
		if (cyc == 20000)
		begin
			mismatches++;
			conclude();
		end
	end
	initial
	begin
		{nrst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
		{ext_irq_i, flag_clr_i, base, lat} = '0;
		{cyc, n, mismatches, comparisons, starts} = '0;
		seed = 32'hF69B5D46;
		{m_lo, m_hi, m_en} = {8'h7D, 8'h04, 8'h7F};
		repeat (2) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		regs();
		rd(8'h06, 8'h00);
		for (i = 0; i < 6; i++)
		begin
			seed = nxt(seed);
			wr(BCR_OFS_IRQ_EN, seed[7:0]);
			m_en = (seed[7:0] & 8'h7C) | 8'h03;
			rd(BCR_OFS_IRQ_EN, m_en);
			@(posedge ref_clk_i);
			ext_irq_i <= seed[12:8];
			repeat (2) @(posedge ref_clk_i);
			#1;
			e = {31'h0, ~|(seed[12:8] & m_en[6:2])};
			chk({8'h00, irq_oe_n_o}, 9'(e));
			chk({8'h00, irq_out_n_o}, 9'(e));
		end
		@(posedge ref_clk_i);
		ext_irq_i <= 5'h00;
		for (i = 0; i < 4; i++)
		begin
			seed = nxt(seed);
			{m_hi, m_lo} = {2'b00, seed[13:0]};
			wr(BCR_OFS_BIAS_LO, m_lo);
			wr(BCR_OFS_BIAS_HI, m_hi);
			regs();
		end
		chk(9'(starts), 9'h000);
		for (i = 0; i < 4; i++)
		begin
			seed = nxt(seed);
			base = seed[8:0];
			lat = seed[12:9];
			e = 0;
			for (j = 0; j < (1 << i); j++)
				e += (base + ((n + j) & 7)) & 511;
			n += 1 << i;
			e = e >> i;
			c = starts;
			m_hi = (m_hi & 8'h27) | 8'(i << 3);
			wr(BCR_OFS_BIAS_HI, m_hi | 8'h80);
			await(0);
			{m_hi[0], m_lo} = e[8:0];
			chk({8'h00, irq_oe_n_o}, 9'h000);
			chk(9'(starts - c), 9'(1 << i));
			regs();
			@(posedge ref_clk_i);
			flag_clr_i <= 2'b10;
			@(posedge ref_clk_i);
			flag_clr_i <= 2'b00;
		end
		lat = 4'h5;
		wr(BCR_OFS_BIAS_HI, m_hi | 8'h40);
		await(1);
		chk(nvm_data_o, {m_hi[0], m_lo});
		await(2);
		chk({8'h00, program_done_flag_o}, 9'h001);
		chk({8'h00, irq_oe_n_o}, 9'h000);
		regs();
		@(posedge ref_clk_i);
		flag_clr_i <= 2'b01;
		@(posedge ref_clk_i);
		flag_clr_i <= 2'b00;
		@(posedge ref_clk_i);
		#1;
		chk({8'h00, program_done_flag_o}, 9'h000);
		chk({8'h00, irq_oe_n_o}, 9'h001);
		conclude();
	end
endmodule : bcr_top_tb
